// *** design/tcc_pkg.sv ***
// constants and decoders for the transfer configuration and software trigger block
// assumes a byte-addressed register port with an access-size input
package tcc_pkg;

    // ------------------------------------------------------------
    // register addresses and access sizes
    // ------------------------------------------------------------
    localparam logic [3:0] CONF_ADDR = 4'h9;
    localparam logic [3:0] TRIG_ADDR = 4'ha;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // ------------------------------------------------------------
    // configuration byte layout and reset values
    // ------------------------------------------------------------
    localparam int CONF_DONE_IRQ_EN_BIT = 0;
    localparam int CONF_ERR_IRQ_EN_BIT = 1;
    localparam int CONF_SKIP_DIS_BIT = 2;
    localparam int CONF_ERR_STOP_EN_BIT = 3;
    localparam int CONF_PRIO_LSB = 4;
    localparam int CONF_RSVD_BIT = 7;
    localparam int PRIO_W = 3;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic CONF_FLAG_RESET = 1'b0;

    // ------------------------------------------------------------
    // trigger halfword layout
    // ------------------------------------------------------------
    localparam int TRIG_DONE_BIT = 15;
    localparam int TRIG_PEND_BIT = 14;
    localparam int DESP_W = 14;
    localparam logic [13:0] DESP_RESET = 14'h0000;

    // ------------------------------------------------------------
    // controller state, priority and error codes
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_NORMAL = 2'h0;
    localparam logic [2:0] PRIO_HIGHEST = 3'h0;
    localparam logic [2:0] PRIO_LOWEST = 3'h7;
    localparam logic [2:0] ERRCODE_SOURCE = 3'h1;
    localparam logic [2:0] ERRCODE_DEST = 3'h2;
    localparam logic [2:0] ERRCODE_STANDBY = 3'h3;
    localparam logic [2:0] ERRCODE_DESC_ACCESS = 3'h4;
    localparam logic [2:0] ERRCODE_DESC_OPEN = 3'h5;
    localparam int CNT_W = 6;

    // contested grants per software win, minus one
    function automatic logic [5:0] tccContestLimit(input logic [2:0] code);
        unique case (code)
            3'h1: tccContestLimit = 6'h01;
            3'h2: tccContestLimit = 6'h02;
            3'h3: tccContestLimit = 6'h06;
            3'h4: tccContestLimit = 6'h0e;
            3'h5: tccContestLimit = 6'h1e;
            3'h6: tccContestLimit = 6'h3e;
            default: tccContestLimit = 6'h00;
        endcase
    endfunction

    // error codes that raise the error interrupt
    function automatic logic tccErrorRaises(input logic [2:0] code);
        tccErrorRaises = (code == ERRCODE_SOURCE) || (code == ERRCODE_DEST) ||
            (code == ERRCODE_DESC_ACCESS) || (code == ERRCODE_DESC_OPEN);
    endfunction

endpackage

// *** design/tcc_sw_arbiter.sv ***
// second-level arbiter between the software request and hardware requests
// assumes transferDone pulses once when the granted transfer ends
`timescale 1ns/10ps
module tcc_sw_arbiter (
    input wire logic clk,
    input wire logic rstN,
    input wire logic swRequest,
    input wire logic hwRequest,
    input wire logic [2:0] priorityCode,
    input wire logic holdStart,
    input wire logic transferDone,
    output logic swGrant,
    output logic hwGrant
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_SW = 3'b010,
        ARB_HW = 3'b100
    } tcc_arb_state_type;

    typedef struct packed {
        tcc_arb_state_type owner;
        logic [5:0] contest;
        logic swGrant;
        logic hwGrant;
    } tcc_arb_type;

    tcc_arb_type st_reg;
    tcc_arb_type st_next;
    logic swWins;

    // ------------------------------------------------------------
    // decision
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.swGrant = 1'b0;
        st_next.hwGrant = 1'b0;
        swWins = 1'b0;
        if (priorityCode == tcc_pkg::PRIO_HIGHEST) begin
            swWins = 1'b1;
        end else if (priorityCode == tcc_pkg::PRIO_LOWEST) begin
            swWins = 1'b0;
        end else begin
            swWins = (st_reg.contest == tcc_pkg::tccContestLimit(priorityCode));
        end
        unique case (st_reg.owner)
            ARB_IDLE: begin
                if (!holdStart) begin
                    if (swRequest && hwRequest) begin
                        if (swWins) begin
                            st_next.owner = ARB_SW;
                            st_next.swGrant = 1'b1;
                            st_next.contest = '0;
                        end else begin
                            st_next.owner = ARB_HW;
                            st_next.hwGrant = 1'b1;
                            st_next.contest = st_reg.contest + 6'h01;
                        end
                    end else if (swRequest) begin
                        st_next.owner = ARB_SW;
                        st_next.swGrant = 1'b1;
                    end else if (hwRequest) begin
                        st_next.owner = ARB_HW;
                        st_next.hwGrant = 1'b1;
                    end
                end
            end
            ARB_SW, ARB_HW: begin
                // a running transfer always completes first
                if (transferDone) begin
                    st_next.owner = ARB_IDLE;
                end
            end
            default: st_next.owner = ARB_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            st_reg <= '{owner: ARB_IDLE, contest: 6'h00, swGrant: 1'b0, hwGrant: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign swGrant = st_reg.swGrant;
    assign hwGrant = st_reg.hwGrant;

endmodule // tcc_sw_arbiter

// *** design/tcc_config_trigger.sv ***
// configuration and software trigger front end of the transfer controller
// holds the configuration byte, trigger halfword, interrupt levels and arbiter
// assumes the transfer engine runs on clk and reports its events as pulses
// assumes command logic supplies the controller state as a level on clk
// assumes the error-stop state itself is held by the engine
`timescale 1ns/10ps
module tcc_config_trigger (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [1:0] regSize,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic [1:0] ctrlState,
    input wire logic [2:0] errorStatusCode,
    input wire logic errorStopFlag,
    input wire logic transferError,
    input wire logic swEndNormal,
    input wire logic swEndAbnormal,
    input wire logic swWaitTrigger,
    input wire logic swClearCmd,
    input wire logic standbyCmd,
    input wire logic chainPointerLoad,
    input wire logic [13:0] chainPointer,
    input wire logic hwRequest,
    input wire logic transferDone,
    output logic swDoneIrq,
    output logic errorIrq,
    output logic readSkipDisable,
    output logic errorStopEnter,
    output logic swStartTrigger,
    output logic [13:0] swDescriptorPointer,
    output logic swGrant,
    output logic hwGrant
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic swDoneIrqEnable;
        logic errorIrqEnable;
        logic readSkipDisable;
        logic errorStopEnable;
        logic [2:0] swPriorityCode;
        logic [2:0] appliedPriority;
        logic swDoneFlag;
        logic swRequestPending;
        logic [13:0] swDescriptorPointer;
        logic swStartTrigger;
        logic swDoneIrq;
        logic errorIrq;
        logic errorStopEnter;
        logic [15:0] rdData;
    } tcc_ctl_type;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam tcc_ctl_type CTL_RESET = '{
        swDoneIrqEnable: tcc_pkg::CONF_FLAG_RESET,
        errorIrqEnable: tcc_pkg::CONF_FLAG_RESET,
        readSkipDisable: tcc_pkg::CONF_FLAG_RESET,
        errorStopEnable: tcc_pkg::CONF_FLAG_RESET,
        swPriorityCode: tcc_pkg::PRIO_RESET,
        appliedPriority: tcc_pkg::PRIO_RESET,
        swDoneFlag: 1'b0,
        swRequestPending: 1'b0,
        swDescriptorPointer: tcc_pkg::DESP_RESET,
        swStartTrigger: 1'b0,
        swDoneIrq: 1'b0,
        errorIrq: 1'b0,
        errorStopEnter: 1'b0,
        rdData: 16'h0000
    };

    // ------------------------------------------------------------
    // internal signals
    // ------------------------------------------------------------
    tcc_ctl_type ctl_reg;
    tcc_ctl_type ctl_next;
    logic [1:0] rstSync_reg;
    logic rstN;
    logic confHit;
    logic trigHit;
    logic byteAccess;
    logic halfAccess;
    logic ctrlNormal;
    logic cfgWrite;
    logic trigWrite;
    logic trigAccept;
    logic swEnd;
    logic swRequestLive;
    logic errCodeRaises;
    logic [7:0] cfgByte;
    logic [15:0] trigHalf;

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    function automatic logic isConfAddr(input logic [3:0] addr);
        isConfAddr = (addr == tcc_pkg::CONF_ADDR);
    endfunction

    function automatic logic isTrigAddr(input logic [3:0] addr);
        isTrigAddr = (addr == tcc_pkg::TRIG_ADDR);
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    assign rstN = rstSync_reg[1];

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    assign confHit = isConfAddr(regAddr);
    assign trigHit = isTrigAddr(regAddr);
    assign byteAccess = (regSize == tcc_pkg::SIZE_BYTE);
    assign halfAccess = (regSize == tcc_pkg::SIZE_HALF);
    assign ctrlNormal = (ctrlState == tcc_pkg::CTRL_NORMAL);
    assign cfgWrite = regWrite && confHit && byteAccess && !ctrlNormal;
    assign trigWrite = regWrite && trigHit && halfAccess;
    assign trigAccept = trigWrite && !ctl_reg.swRequestPending && ctrlNormal &&
        !errorStopFlag;
    assign swEnd = swEndNormal || swEndAbnormal || swWaitTrigger;
    // the pending flag falls one edge after the end pulse; mask it meanwhile
    assign swRequestLive = ctl_reg.swRequestPending && !swEnd;
    assign errCodeRaises = tcc_pkg::tccErrorRaises(errorStatusCode);

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    always_comb begin
        cfgByte = 8'h00;
        cfgByte[tcc_pkg::CONF_DONE_IRQ_EN_BIT] = ctl_reg.swDoneIrqEnable;
        cfgByte[tcc_pkg::CONF_ERR_IRQ_EN_BIT] = ctl_reg.errorIrqEnable;
        cfgByte[tcc_pkg::CONF_SKIP_DIS_BIT] = ctl_reg.readSkipDisable;
        cfgByte[tcc_pkg::CONF_ERR_STOP_EN_BIT] = ctl_reg.errorStopEnable;
        cfgByte[tcc_pkg::CONF_PRIO_LSB +: tcc_pkg::PRIO_W] = ctl_reg.swPriorityCode;
        cfgByte[tcc_pkg::CONF_RSVD_BIT] = 1'b0;
    end

    always_comb begin
        trigHalf = 16'h0000;
        trigHalf[tcc_pkg::TRIG_DONE_BIT] = ctl_reg.swDoneFlag;
        trigHalf[tcc_pkg::TRIG_PEND_BIT] = ctl_reg.swRequestPending;
        trigHalf[tcc_pkg::DESP_W - 1:0] = ctl_reg.swDescriptorPointer;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.swStartTrigger = 1'b0;
        ctl_next.errorStopEnter = 1'b0;
        ctl_next.rdData = 16'h0000;

        // --------------------------------------------------------
        // configuration byte, reserved bit never stored
        // --------------------------------------------------------
        if (cfgWrite) begin
            ctl_next.swDoneIrqEnable = regWrData[tcc_pkg::CONF_DONE_IRQ_EN_BIT];
            ctl_next.errorIrqEnable = regWrData[tcc_pkg::CONF_ERR_IRQ_EN_BIT];
            ctl_next.readSkipDisable = regWrData[tcc_pkg::CONF_SKIP_DIS_BIT];
            ctl_next.errorStopEnable = regWrData[tcc_pkg::CONF_ERR_STOP_EN_BIT];
            ctl_next.swPriorityCode =
                regWrData[tcc_pkg::CONF_PRIO_LSB +: tcc_pkg::PRIO_W];
        end

        // --------------------------------------------------------
        // software start trigger
        // --------------------------------------------------------
        if (trigAccept) begin
            ctl_next.swStartTrigger = 1'b1;
            ctl_next.swDescriptorPointer = regWrData[tcc_pkg::DESP_W - 1:0];
            ctl_next.appliedPriority = ctl_reg.swPriorityCode;
        end else if (chainPointerLoad && ctl_reg.swRequestPending) begin
            ctl_next.swDescriptorPointer = chainPointer;
        end

        // --------------------------------------------------------
        // pending flag: an accepted trigger cannot meet an end pulse
        // --------------------------------------------------------
        if (trigAccept) begin
            ctl_next.swRequestPending = 1'b1;
        end else if (swEnd) begin
            ctl_next.swRequestPending = 1'b0;
        end

        // --------------------------------------------------------
        // done flag: a normal end wins over any clear
        // --------------------------------------------------------
        if (swEndNormal) begin
            ctl_next.swDoneFlag = 1'b1;
        end else if (swClearCmd || standbyCmd || trigAccept) begin
            ctl_next.swDoneFlag = 1'b0;
        end

        // --------------------------------------------------------
        // error stop request towards the engine
        // --------------------------------------------------------
        if (transferError && ctl_reg.errorStopEnable) begin
            ctl_next.errorStopEnter = 1'b1;
        end else begin
            ctl_next.errorStopEnter = 1'b0;
        end

        // --------------------------------------------------------
        // interrupt levels
        // --------------------------------------------------------
        ctl_next.swDoneIrq = ctl_next.swDoneIrqEnable && ctl_next.swDoneFlag;
        ctl_next.errorIrq = ctl_next.errorIrqEnable &&
            errCodeRaises;

        // --------------------------------------------------------
        // read data, valid in the cycle after the strobe only
        // --------------------------------------------------------
        if (regRead) begin
            if (confHit) begin
                ctl_next.rdData = {8'h00, cfgByte};
            end else if (trigHit) begin
                ctl_next.rdData = trigHalf;
            end else begin
                ctl_next.rdData = 16'h0000; // unmapped addresses read zero
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctl_reg <= CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------
    // arbitration between software and hardware requests
    // ------------------------------------------------------------
    tcc_sw_arbiter arbiter (
        .clk(clk),
        .rstN(rstN),
        .swRequest(swRequestLive),
        .hwRequest(hwRequest),
        .priorityCode(ctl_reg.appliedPriority),
        .holdStart(errorStopFlag),
        .transferDone(transferDone),
        .swGrant(swGrant),
        .hwGrant(hwGrant)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdData = ctl_reg.rdData;
    assign swDoneIrq = ctl_reg.swDoneIrq;
    assign errorIrq = ctl_reg.errorIrq;
    assign readSkipDisable = ctl_reg.readSkipDisable;
    assign errorStopEnter = ctl_reg.errorStopEnter;
    assign swStartTrigger = ctl_reg.swStartTrigger;
    assign swDescriptorPointer = ctl_reg.swDescriptorPointer;

endmodule // tcc_config_trigger

// *** dv/tcc_config_trigger_sva.sv ***
// assertions for the configuration and software trigger block
// assumes binding onto tcc_config_trigger, single clock clk, reset arst_n
`timescale 1ns/10ps
module tcc_config_trigger_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] regAddr,
    input wire logic [1:0] regSize,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regRdData,
    input wire logic [1:0] ctrlState,
    input wire logic [2:0] errorStatusCode,
    input wire logic errorStopFlag,
    input wire logic transferError,
    input wire logic hwRequest,
    input wire logic errorIrq,
    input wire logic readSkipDisable,
    input wire logic errorStopEnter,
    input wire logic swStartTrigger,
    input wire logic [13:0] swDescriptorPointer,
    input wire logic swGrant,
    input wire logic hwGrant
);
    logic cfgWrOk;
    logic trigWrOk;
    assign cfgWrOk = regWrite && regAddr == tcc_pkg::CONF_ADDR && regSize == tcc_pkg::SIZE_BYTE
        && ctrlState != tcc_pkg::CTRL_NORMAL;
    assign trigWrOk = regWrite && regAddr == tcc_pkg::TRIG_ADDR && regSize == tcc_pkg::SIZE_HALF
        && ctrlState == tcc_pkg::CTRL_NORMAL && !errorStopFlag;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // register port and configuration
    // ------------------------------------------------------------
    a_reserved_zero: assert property (
        $past(regRead) && $past(regAddr) == tcc_pkg::CONF_ADDR |-> regRdData[15:7] == 9'h000)
        else $error("configuration read shows reserved bits set");
    a_skip_write_only: assert property (
        $changed(readSkipDisable) |-> $past(cfgWrOk) || $past(cfgWrOk, 2))
        else $error("read skip disable changed without an accepted byte write");
    // ------------------------------------------------------------
    // interrupts and error stop
    // ------------------------------------------------------------
    a_err_standby_quiet: assert property (
        $past(errorStatusCode) == tcc_pkg::ERRCODE_STANDBY |-> !errorIrq)
        else $error("error interrupt raised for standby stop code");
    a_err_irq_cause: assert property (
        errorIrq |-> $past(errorStatusCode) inside {3'h1, 3'h2, 3'h4, 3'h5})
        else $error("error interrupt raised for a code that does not raise it");
    a_stop_enter_pulse: assert property (
        errorStopEnter |-> $past(transferError) ##1 !errorStopEnter)
        else $error("error stop entry without a transfer error or too long");
    // ------------------------------------------------------------
    // trigger and arbitration
    // ------------------------------------------------------------
    a_trig_accept: assert property (
        swStartTrigger |-> $past(trigWrOk))
        else $error("start trigger without an acceptable trigger write");
    a_trig_pointer: assert property (
        swStartTrigger |-> swDescriptorPointer == $past(regWrData[13:0]) ##1 !swStartTrigger)
        else $error("trigger pointer wrong or trigger pulse too long");
    a_grant_onehot: assert property (
        !(swGrant && hwGrant))
        else $error("both grants at once");
    a_stop_no_grant: assert property (
        $past(errorStopFlag) |-> !swGrant && !hwGrant)
        else $error("grant issued in error stop state");
    a_hw_grant_cause: assert property (
        hwGrant |-> $past(hwRequest))
        else $error("hardware grant without hardware request");
endmodule // tcc_config_trigger_sva

bind tcc_config_trigger tcc_config_trigger_sva i_tcc_config_trigger_sva (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regSize(regSize), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .ctrlState(ctrlState),
    .errorStatusCode(errorStatusCode), .errorStopFlag(errorStopFlag),
    .transferError(transferError), .hwRequest(hwRequest), .errorIrq(errorIrq),
    .readSkipDisable(readSkipDisable), .errorStopEnter(errorStopEnter),
    .swStartTrigger(swStartTrigger), .swDescriptorPointer(swDescriptorPointer),
    .swGrant(swGrant), .hwGrant(hwGrant));

// *** dv/tb_top.sv ***
// self-checking testbench for the configuration and software trigger block
// assumes the package, design and checker files are compiled before it
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [1:0] regSize = 2'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0, regRead = 1'b0, hwRequest = 1'b0, swClearCmd = 1'b0;
    logic [1:0] ctrlState = 2'h1;
    logic [2:0] errorStatusCode = 3'h0;
    logic errorStopFlag = 1'b0, transferError = 1'b0, swEndNormal = 1'b0, transferDone = 1'b0;
    logic [15:0] regRdData;
    logic swDoneIrq, errorIrq, readSkipDisable, errorStopEnter, swStartTrigger, swGrant, hwGrant;
    logic [13:0] swDescriptorPointer;
    int fail_count = 0;
    int total_checks = 0;
    // state, size, write data, expected readback
    logic [23:0] rows [6] = '{24'h100f0f, 24'h11740f, 24'h12740f, 24'h00740f, 24'h20f474,
        24'h300b0b};

    always #12.5 clk = ~clk;

    tcc_config_trigger i_tcc_config_trigger (
        .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regSize(regSize), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .ctrlState(ctrlState),
        .errorStatusCode(errorStatusCode), .errorStopFlag(errorStopFlag),
        .transferError(transferError), .swEndNormal(swEndNormal), .swEndAbnormal(1'b0),
        .swWaitTrigger(1'b0), .swClearCmd(swClearCmd), .standbyCmd(1'b0),
        .chainPointerLoad(1'b0), .chainPointer(14'h0000), .hwRequest(hwRequest),
        .transferDone(transferDone), .swDoneIrq(swDoneIrq), .errorIrq(errorIrq),
        .readSkipDisable(readSkipDisable), .errorStopEnter(errorStopEnter),
        .swStartTrigger(swStartTrigger), .swDescriptorPointer(swDescriptorPointer),
        .swGrant(swGrant), .hwGrant(hwGrant));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [1:0] s, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regSize <= s;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdData, e);
    endtask

    task automatic set_state(input logic [1:0] s);
        @(posedge clk) ctrlState <= s;
    endtask

    task automatic pulse_done(input logic swEnd, input logic dropHw);
        @(posedge clk);
        transferDone <= 1'b1;
        swEndNormal <= swEnd;
        if (dropHw) begin
            hwRequest <= 1'b0;
        end
        @(posedge clk);
        transferDone <= 1'b0;
        swEndNormal <= 1'b0;
    endtask

    task automatic wait_grant(output logic isSw);
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (swGrant === 1'b1 || hwGrant === 1'b1) break;
        end
        if (n == 40) begin
            fail_count++;
            $display("unexpected at %0t: no grant", $time);
            close_out();
        end
        isSw = (swGrant === 1'b1);
    endtask

    // hw transfer running, sw trigger, then count hw wins before sw wins
    task automatic run_arb(input logic [2:0] code, input logic [2:0] later, input int dropAt,
        input int expHw);
        int hwCount;
        logic isSw;
        logic [13:0] ptr;
        hwCount = 0;
        ptr = {7'h04, code, 4'h0};
        set_state(2'h1);
        wr(tcc_pkg::CONF_ADDR, tcc_pkg::SIZE_BYTE, {9'h000, code, 4'h1});
        @(posedge clk);
        ctrlState <= 2'h0;
        hwRequest <= 1'b1;
        wait_grant(isSw);
        wr(tcc_pkg::TRIG_ADDR, tcc_pkg::SIZE_HALF, {2'b00, ptr});
        #1 chk(16'(swStartTrigger), 16'h0001);
        wr(tcc_pkg::TRIG_ADDR, tcc_pkg::SIZE_HALF, 16'h0000);
        #1 chk(16'(swStartTrigger), 16'h0000);
        rd(tcc_pkg::TRIG_ADDR, {2'b01, ptr});
        chk(16'(swDoneIrq), 16'h0000);
        set_state(2'h1);
        wr(tcc_pkg::CONF_ADDR, tcc_pkg::SIZE_BYTE, {9'h000, later, 4'h1});
        set_state(2'h0);
        pulse_done(1'b0, 1'b0);
        for (int i = 0; i < 80; i++) begin
            wait_grant(isSw);
            if (isSw) break;
            hwCount++;
            pulse_done(1'b0, hwCount == dropAt);
        end
        chk(16'(hwCount), 16'(expHw));
        pulse_done(1'b1, 1'b1);
        #1 chk(16'(swDoneIrq), 16'h0001);
        rd(tcc_pkg::TRIG_ADDR, {2'b10, ptr});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(tcc_pkg::CONF_ADDR, 16'h0040);
        rd(tcc_pkg::TRIG_ADDR, 16'h0000);
        rd(4'h3, 16'h0000);
        foreach (rows[i]) begin
            set_state(rows[i][21:20]);
            wr(tcc_pkg::CONF_ADDR, rows[i][17:16], {8'h00, rows[i][15:8]});
            rd(tcc_pkg::CONF_ADDR, {8'h00, rows[i][7:0]});
            chk(16'(readSkipDisable), 16'(rows[i][2]));
        end
        for (int en = 0; en < 2; en++) begin
            wr(tcc_pkg::CONF_ADDR, tcc_pkg::SIZE_BYTE, 16'(en * 2));
            for (int c = 0; c < 8; c++) begin
                @(posedge clk) errorStatusCode <= 3'(c);
                repeat (2) @(posedge clk);
                #1 chk(16'(errorIrq), 16'(en == 1 && (c == 1 || c == 2 || c == 4 || c == 5)));
            end
        end
        @(posedge clk) errorStatusCode <= 3'h0;
        for (int en = 0; en < 2; en++) begin
            wr(tcc_pkg::CONF_ADDR, tcc_pkg::SIZE_BYTE, 16'(en * 8));
            @(posedge clk) transferError <= 1'b1;
            @(posedge clk) transferError <= 1'b0;
            #1 chk(16'(errorStopEnter), 16'(en));
        end
        @(posedge clk);
        ctrlState <= 2'h0;
        errorStopFlag <= 1'b1;
        wr(tcc_pkg::TRIG_ADDR, tcc_pkg::SIZE_HALF, 16'h0040);
        #1 chk(16'(swStartTrigger), 16'h0000);
        @(posedge clk) errorStopFlag <= 1'b0;
        run_arb(3'h1, 3'h1, 0, 1);
        run_arb(3'h4, 3'h4, 0, 14);
        run_arb(3'h7, 3'h0, 5, 5);
        run_arb(3'h0, 3'h0, 0, 0);
        @(posedge clk) swClearCmd <= 1'b1;
        @(posedge clk) swClearCmd <= 1'b0;
        #1 chk(16'(swDoneIrq), 16'h0000);
        close_out();
    end
endmodule // tb_top
